// ---- design/lbd_defines.svh ----
`ifndef LBD_DEFINES_SVH
`define LBD_DEFINES_SVH
// ============================================================
// Register map (word byte addresses)
`define LBD_REG_BRIGHT 4'h0
`define LBD_REG_CTRL 4'h4
`define LBD_REG_STATUS 4'h8
`define LBD_REG_CHAN 4'hC
// ============================================================
// Control fields
`define LBD_CTRL_ENABLE 0
`define LBD_CTRL_REACT 1
// ============================================================
// Reset values
`define LBD_BRIGHT_RST 8'hFF
`define LBD_FULL_SCALE 8'hFF
// ============================================================
// Timing and voltage levels
`define LBD_CLK_HZ 125000000
`define LBD_PULSE_MIN_HZ 200
`define LBD_PULSE_MAX_HZ 20000
`define LBD_DIM_MIN_HZ 200
`define LBD_DIM_MAX_HZ 5000
`define LBD_STEP_MV 100
`define LBD_REG_MV 450
`define LBD_UNUSED_MV 750
`define LBD_PULSE_TIMEOUT_CYC ((`LBD_CLK_HZ / `LBD_PULSE_MIN_HZ) * 2)
`endif

// ---- design/lbd_pkg.sv ----
package lbd_pkg;
  typedef enum logic [1:0] {
    LBD_DIM_NODELAY = 2'b00,
    LBD_DIM_ANALOG = 2'b01,
    LBD_DIM_DIRECT = 2'b10
  } lbd_dim_mode_t;
  typedef enum logic [1:0] {
    LBD_STRAP_LOW = 2'b00,
    LBD_STRAP_OPEN = 2'b01,
    LBD_STRAP_HIGH = 2'b10
  } lbd_strap_t;
  typedef enum logic [3:0] {
    LBD_SS_OFF = 4'b0001,
    LBD_SS_WAIT = 4'b0010,
    LBD_SS_RAMP = 4'b0100,
    LBD_SS_RUN = 4'b1000
  } lbd_ss_state_t;
endpackage

// ---- design/lbd_duty_meter.sv ----
`timescale 1ns/1ps
`include "lbd_defines.svh"
module lbd_duty_meter
  import lbd_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int TIMEOUT = `LBD_PULSE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pulse
  input wire logic pulse_in,
  // Result
  output logic [7:0] duty,
  output logic duty_valid,
  output logic active
);
  // ============================================================
  // Period and high-time counters, restart each rising edge
  logic prev_q, prev_d;
  logic [CNT_W-1:0] per_q, per_d, hi_q, hi_d;
  logic [7:0] duty_q, duty_d;
  logic vld_q, vld_d, act_q, act_d;
  logic [CNT_W+7:0] prod;
  logic [CNT_W+7:0] quo;

  always_comb begin
    prev_d = pulse_in;
    per_d = per_q;
    hi_d = hi_q;
    duty_d = duty_q;
    vld_d = 1'b0;
    act_d = act_q;
    prod = {8'h00, hi_q} * (CNT_W+8)'(255);
    quo = (per_q == '0) ? '0 : prod / {8'h00, per_q};
    if (pulse_in && !prev_q) begin
      // Full-resolution count adapts to any period in range
      if (act_q) begin
        duty_d = quo[7:0];
        vld_d = 1'b1;
      end
      act_d = 1'b1;
      per_d = CNT_W'(1);
      hi_d = CNT_W'(1);
    end else if (per_q >= CNT_W'(TIMEOUT)) begin
      // Steady level: high maps to full scale, low to zero
      duty_d = pulse_in ? `LBD_FULL_SCALE : 8'h00;
      vld_d = 1'b1;
      act_d = pulse_in;
      per_d = '0;
      hi_d = '0;
    end else begin
      per_d = per_q + CNT_W'(1);
      hi_d = hi_q + (pulse_in ? CNT_W'(1) : CNT_W'(0));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= 1'b0;
      per_q <= '0;
      hi_q <= '0;
      duty_q <= 8'h00;
      vld_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      per_q <= per_d;
      hi_q <= hi_d;
      duty_q <= duty_d;
      vld_q <= vld_d;
      act_q <= act_d;
    end
  end

  assign duty = duty_q;
  assign duty_valid = vld_q;
  assign active = act_q;
endmodule // lbd_duty_meter

// ---- design/lbd_dim_osc.sv ----
`timescale 1ns/1ps
`include "lbd_defines.svh"
module lbd_dim_osc
  import lbd_pkg::*;
#(
  parameter int DIV_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Setting
  input wire logic [DIV_W-1:0] step_div,
  input wire logic [7:0] duty,
  // Output
  output logic pwm
);
  // ============================================================
  // Prescaler: 256 slots per dimming period
  logic [DIV_W-1:0] pre_q, pre_d;
  logic [7:0] slot_q, slot_d;
  logic pwm_q, pwm_d;

  always_comb begin
    pre_d = pre_q + DIV_W'(1);
    slot_d = slot_q;
    if (pre_q >= step_div) begin
      pre_d = '0;
      slot_d = slot_q + 8'h01;
    end
    pwm_d = (duty == `LBD_FULL_SCALE) || (slot_q < duty);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_q <= '0;
      slot_q <= 8'h00;
      pwm_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      slot_q <= slot_d;
      pwm_q <= pwm_d;
    end
  end

  assign pwm = pwm_q;
endmodule // lbd_dim_osc

// ---- design/lbd_backlight_ctrl.sv ----
`timescale 1ns/1ps
`include "lbd_defines.svh"
module lbd_backlight_ctrl
  import lbd_pkg::*;
#(
  parameter int NCH = 8,
  parameter int DIV_W = 20,
  parameter int TIMEOUT = `LBD_PULSE_TIMEOUT_CYC,
  parameter logic [DIV_W-1:0] DIM_STEP_DIV = DIV_W'(`LBD_CLK_HZ / (`LBD_DIM_MIN_HZ * 256))
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Straps and enable
  input wire logic [1:0] interface_select_strap,
  input wire logic [1:0] dimming_select_strap,
  input wire logic enable,
  // Brightness pulse
  input wire logic brightness_pulse_input,
  // Dimming oscillator divider from the resistor setting
  input wire logic [DIV_W-1:0] dim_oscillator_set_pin,
  // Channel analog feedback comparators
  input wire logic [NCH-1:0] chan_below_unused,
  input wire logic [NCH-1:0] chan_above_reg,
  input wire logic [NCH-1:0] chan_current_ok,
  input wire logic [NCH-1:0] chan_zero_current,
  input wire logic output_at_ovp,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sink drive
  output logic [NCH-1:0] led_channel_sink,
  output logic [7:0] sink_amplitude,
  output logic step_up,
  output logic [7:0] target_steps,
  output logic device_on
);
  // ============================================================
  // Strap decode
  function automatic logic [2:0] decode_straps(input logic [1:0] s1, input logic [1:0] s2);
    // {valid, bus_if, analog/direct select encoded via return path}
    decode_straps = 3'b000;
    if (s1 == LBD_STRAP_HIGH && s2 == LBD_STRAP_LOW) decode_straps = 3'b110;
    else if (s1 == LBD_STRAP_OPEN && s2 == LBD_STRAP_LOW) decode_straps = 3'b100;
    else if (s1 == LBD_STRAP_LOW && s2 == LBD_STRAP_HIGH) decode_straps = 3'b111;
    else if (s1 == LBD_STRAP_LOW && s2 == LBD_STRAP_OPEN) decode_straps = 3'b101;
    else if (s1 == LBD_STRAP_LOW && s2 == LBD_STRAP_LOW) decode_straps = 3'b100;
  endfunction

  logic [2:0] dec;
  lbd_dim_mode_t mode_q, mode_d;
  logic bus_if_q, bus_if_d;

  always_comb begin
    dec = decode_straps(interface_select_strap, dimming_select_strap);
    bus_if_d = dec[1];
    if (!dec[2]) mode_d = LBD_DIM_NODELAY;
    else if (dec[0]) mode_d = LBD_DIM_ANALOG;
    else if (interface_select_strap == LBD_STRAP_LOW) mode_d = LBD_DIM_DIRECT;
    else mode_d = LBD_DIM_NODELAY;
  end

  // ============================================================
  // Duty meter and oscillator
  logic [7:0] meas_duty;
  logic meas_valid, pulse_active;
  logic [7:0] bright_q, bright_d;
  logic osc_pwm;

  lbd_duty_meter #(.CNT_W(24), .TIMEOUT(TIMEOUT)) u_meter (
    .clk(clk),
    .srst(srst),
    .pulse_in(brightness_pulse_input),
    .duty(meas_duty),
    .duty_valid(meas_valid),
    .active(pulse_active)
  );

  lbd_dim_osc #(.DIV_W(DIV_W)) u_osc (
    .clk(clk),
    .srst(srst),
    .step_div(dim_oscillator_set_pin),
    .duty(bright_q),
    .pwm(osc_pwm)
  );

  // ============================================================
  // Bus slave and brightness register
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic en_sw_q, en_sw_d;
  logic react;
  lbd_ss_state_t ss_q, ss_d;
  logic [NCH-1:0] removed_q, removed_d;
  logic [7:0] steps_q, steps_d;
  logic en_prev_q;
  logic run_en;

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    bright_d = bright_q;
    en_sw_d = en_sw_q;
    react = 1'b0;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      if (avs_read) begin
        unique case (avs_address)
          `LBD_REG_BRIGHT: rdata_d = {24'h0000_00, bright_q};
          `LBD_REG_CTRL: rdata_d = {30'h0000_0000, 1'b0, en_sw_q};
          `LBD_REG_STATUS: rdata_d = {24'h0000_00, ss_q, bus_if_q, pulse_active, mode_q};
          `LBD_REG_CHAN: rdata_d = 32'(removed_q);
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (avs_write && wait_q && avs_byteenable[0]) begin
      if (avs_address == `LBD_REG_BRIGHT && bus_if_q) bright_d = avs_writedata[7:0];
      if (avs_address == `LBD_REG_CTRL) begin
        en_sw_d = avs_writedata[`LBD_CTRL_ENABLE];
        react = avs_writedata[`LBD_CTRL_REACT];
      end
    end
    if (!bus_if_q && meas_valid) bright_d = meas_duty;
  end

  // ============================================================
  // Soft start and channel removal
  always_comb begin
    run_en = enable && en_sw_q;
    ss_d = ss_q;
    steps_d = steps_q;
    // Clear first, so a removal in the same cycle wins
    removed_d = (react || (run_en && !en_prev_q)) ? '0 : removed_q;
    unique case (ss_q)
      LBD_SS_OFF: begin
        steps_d = 8'h00;
        if (run_en) begin
          removed_d = chan_below_unused;
          ss_d = LBD_SS_WAIT;
        end
      end
      LBD_SS_WAIT: if (pulse_active || bus_if_q) ss_d = LBD_SS_RAMP;
      LBD_SS_RAMP: begin
        if (output_at_ovp) removed_d = removed_d | chan_zero_current;
        if (&((chan_above_reg & chan_current_ok) | removed_q)) ss_d = LBD_SS_RUN;
        else steps_d = steps_q + 8'h01;
      end
      LBD_SS_RUN: ;
    endcase
    if (!run_en) ss_d = LBD_SS_OFF;
  end

  logic [NCH-1:0] sink_q, sink_d;
  logic [7:0] amp_q, amp_d;
  logic gate;

  always_comb begin
    unique case (mode_q)
      LBD_DIM_NODELAY: gate = osc_pwm;
      LBD_DIM_DIRECT: gate = brightness_pulse_input;
      default: gate = 1'b1;
    endcase
    amp_d = (mode_q == LBD_DIM_ANALOG) ? bright_q : `LBD_FULL_SCALE;
    sink_d = (ss_q == LBD_SS_RAMP || ss_q == LBD_SS_RUN) && gate ? ~removed_q : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= LBD_DIM_NODELAY;
      bus_if_q <= 1'b0;
      bright_q <= `LBD_BRIGHT_RST;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
      en_sw_q <= 1'b1;
      ss_q <= LBD_SS_OFF;
      steps_q <= 8'h00;
      removed_q <= '0;
      en_prev_q <= 1'b0;
      sink_q <= '0;
      amp_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      bus_if_q <= bus_if_d;
      bright_q <= bright_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      en_sw_q <= en_sw_d;
      ss_q <= ss_d;
      steps_q <= steps_d;
      removed_q <= removed_d;
      en_prev_q <= run_en;
      sink_q <= sink_d;
      amp_q <= amp_d;
    end
  end

  logic step_q;
  logic on_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      step_q <= 1'b0;
      on_q <= 1'b0;
    end else begin
      step_q <= (ss_q == LBD_SS_RAMP) && (ss_d == LBD_SS_RAMP);
      on_q <= run_en;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign led_channel_sink = sink_q;
  assign sink_amplitude = amp_q;
  assign step_up = step_q;
  assign target_steps = steps_q;
  assign device_on = on_q;
endmodule // lbd_backlight_ctrl

// ---- testbench/lbd_host_pulse.sv ----
`timescale 1ns/1ps
// ====
// Host pulse source
module lbd_host_pulse (
  // Clock
  input wire logic clk,
  // Shape
  input wire logic [15:0] period,
  input wire logic [15:0] high,
  // Pulse
  output logic pulse
);
  logic [15:0] cnt_q;
  initial cnt_q = 16'h0000;
  initial pulse = 1'b0;
  always @(posedge clk) begin
    cnt_q <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
    pulse <= cnt_q < high;
  end
endmodule // lbd_host_pulse

// ---- testbench/lbd_backlight_ctrl_properties.sv ----
`timescale 1ns/1ps
// ====
// Port checker
module lbd_backlight_ctrl_properties #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs
  input wire logic [1:0] interface_select_strap,
  input wire logic [1:0] dimming_select_strap,
  input wire logic enable,
  input wire logic brightness_pulse_input,
  input wire logic [NCH-1:0] chan_above_reg,
  input wire logic [NCH-1:0] chan_current_ok,
  input wire logic avs_read,
  input wire logic avs_write,
  // Outputs
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NCH-1:0] led_channel_sink,
  input wire logic [7:0] sink_amplitude,
  input wire logic step_up,
  input wire logic device_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic direct_m;
  logic analog_m;
  assign direct_m = interface_select_strap == 2'b00 && dimming_select_strap == 2'b00;
  assign analog_m = interface_select_strap == 2'b00 && dimming_select_strap != 2'b00;
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_hold;
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest);
  endproperty
  a_hold: assert property (p_hold) else $error("readdata moved");
  property p_off;
    !enable |=> !device_on;
  endproperty
  a_off: assert property (p_off) else $error("still on");
  property p_dark;
    !enable [*3] |-> led_channel_sink == '0;
  endproperty
  a_dark: assert property (p_dark) else $error("sinks lit when off");
  property p_direct_low;
    (direct_m && !brightness_pulse_input) [*6] |-> led_channel_sink == '0;
  endproperty
  a_direct_low: assert property (p_direct_low) else $error("direct low lit");
  property p_direct_high;
    (direct_m && brightness_pulse_input && device_on) [*6] |-> led_channel_sink != '0;
  endproperty
  a_direct_high: assert property (p_direct_high) else $error("direct high dark");
  property p_amp;
    (!analog_m && device_on) [*4] |-> sink_amplitude == 8'hFF;
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude scaled");
  property p_step;
    (chan_above_reg == '1 && chan_current_ok == '1) [*4] |-> !step_up;
  endproperty
  a_step: assert property (p_step) else $error("step after regulation");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_step: cover property (step_up);
  c_direct: cover property (direct_m && led_channel_sink == '1);
endmodule // lbd_backlight_ctrl_properties
bind lbd_backlight_ctrl lbd_backlight_ctrl_properties #(.NCH(NCH)) lbd_backlight_ctrl_properties_inst (
  .clk, .srst, .interface_select_strap, .dimming_select_strap, .enable, .brightness_pulse_input,
  .chan_above_reg, .chan_current_ok, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .led_channel_sink, .sink_amplitude, .step_up, .device_on);

// ---- testbench/lbd_backlight_ctrl_tb.sv ----
`timescale 1ns/1ps
// ====
// Self-checking bench
module lbd_backlight_ctrl_tb;
  import lbd_pkg::*;
  logic clk = 1'b0, srst = 1'b1, en = 1'b1, pulse, ovp = 1'b0, rd = 1'b0, wr = 1'b0;
  logic wreq, step, on;
  logic [1:0] isel = 2'b01, dsel = 2'b00;
  logic [19:0] osc = 20'h0_0003;
  logic [7:0] below = 8'h00, above = 8'hFF, ok = 8'hFF, zero = 8'h00, sinks, amp, tsteps, b;
  logic [3:0] adr = 4'h0, be = 4'hF;
  logic [31:0] wd = 32'h0000_0000, rdata, q, e;
  logic [31:0] seed = 32'h0000_E013;
  logic [15:0] hi = 16'h0000;
  logic [3:0] tbl [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'hA};
  int n_fail = 0, checks_done = 0, k, cnt, bad;
  always #4 clk = ~clk;
  lbd_host_pulse lbd_host_pulse_inst (.clk(clk), .period(16'h186A), .high(hi), .pulse(pulse));
  lbd_backlight_ctrl #(.TIMEOUT(8000)) lbd_backlight_ctrl_inst (
    .clk(clk), .srst(srst), .interface_select_strap(isel), .dimming_select_strap(dsel), .enable(en),
    .brightness_pulse_input(pulse), .dim_oscillator_set_pin(osc), .chan_below_unused(below),
    .chan_above_reg(above), .chan_current_ok(ok), .chan_zero_current(zero), .output_at_ovp(ovp),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .led_channel_sink(sinks), .sink_amplitude(amp),
    .step_up(step), .target_steps(tsteps), .device_on(on));
  // ====
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [2:0] exp_mode(input logic [3:0] s);
    logic [1:0] m;
    m = s[3:2] != 2'b00 ? LBD_DIM_NODELAY : (s[1:0] == 2'b00 ? LBD_DIM_DIRECT : LBD_DIM_ANALOG);
    return {s == 4'h8 || s == 4'h2, m};
  endfunction
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask
  task automatic near(input logic [31:0] got, input logic [31:0] exp, input int tol, input string m);
    checks_done++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) fail(m);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      i++;
    end while (wreq !== 1'b0 && i < 50);
    q = rdata;
    if (i >= 50) begin
      fail("bus timeout");
      tally_and_finish();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic measure(input int n);
    cnt = 0;
    bad = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += int'(sinks == 8'hFF);
      bad += int'(sinks !== 8'hFF && sinks !== 8'h00);
    end
  endtask
  task automatic toggle();
    @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    en <= 1'b1;
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_00FF, "bright reset");
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped read");
    for (k = 0; k < 6; k++) begin
      {isel, dsel} <= tbl[k];
      repeat (4) @(posedge clk);
      bus(1'b0, 4'h8, 32'h0000_0000);
      chk({q[3], q[1:0]}, exp_mode(tbl[k]), "strap decode");
    end
    {isel, dsel} <= 4'h8;
    for (k = 0; k < 2; k++) begin
      b = k ? 8'h00 : 8'(xs());
      bus(1'b1, 4'h0, {24'h00_0000, b});
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk(q, {24'h00_0000, b}, "bus bright");
      repeat (2048) @(posedge clk);
      measure(1024);
      near(cnt, 32'(b) * 4, 8, "dim duty");
      chk(bad, 0, "channels apart");
    end
    @(posedge clk);
    be <= 4'h0;
    bus(1'b1, 4'h0, 32'h0000_0055);
    be <= 4'hF;
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0000, "masked write");
    below <= 8'h08;
    zero <= 8'h20;
    ok <= 8'h00;
    ovp <= 1'b1;
    toggle();
    cnt = 0;
    repeat (2000) @(negedge clk) cnt += int'(step === 1'b1);
    chk(cnt != 0, 1, "ramp steps");
    @(posedge clk);
    {below, zero, ok, ovp} <= {8'h00, 8'h00, 8'hFF, 1'b0};
    repeat (50) @(posedge clk);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(q, 32'h0000_0028, "removed mask");
    bus(1'b1, 4'h4, 32'h0000_0003);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(q, 32'h0000_0000, "reactivated");
    {isel, dsel} <= 4'h4;
    for (k = 0; k < 3; k++) begin
      if (k == 2) {isel, dsel} <= 4'h1;
      hi <= 16'(xs() % 6249 + 1);
      repeat (13000) @(posedge clk);
      e = 32'(hi) * 255 / 6250;
      bus(1'b0, 4'h0, 32'h0000_0000);
      near(q, e, 2, "measured duty");
    end
    near(amp, e, 2, "amplitude");
    chk(sinks, 8'hFF, "analog sinks on");
    {isel, dsel} <= 4'h4;
    hi <= 16'h186A;
    repeat (10000) @(posedge clk);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_00FF, "steady high");
    hi <= 16'h0000;
    repeat (10000) @(posedge clk);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0000, "steady low");
    toggle();
    repeat (500) @(posedge clk);
    chk(tsteps, 8'h00, "no pulse minimum");
    chk(sinks, 8'h00, "no pulse sinks off");
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q[7:4], LBD_SS_WAIT, "waits for pulse");
    {isel, dsel} <= 4'h0;
    hi <= 16'h0BB8;
    repeat (7000) @(posedge clk);
    measure(6250);
    near(cnt, 3000, 8, "direct duty");
    chk(bad, 0, "direct apart");
    @(posedge clk);
    en <= 1'b0;
    repeat (5) @(posedge clk);
    chk(on, 1'b0, "shutdown");
    tally_and_finish();
  end
endmodule // lbd_backlight_ctrl_tb
